// ===== verilog/upc_cfg.svh
// Offsets, field positions, reset values and the standard cell length of the port clock watch
`ifndef UPC_CFG_SVH
`define UPC_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UPC_OFF_CTRL   8'h00
`define UPC_OFF_LIMITS 8'h14
`define UPC_OFF_IEN    8'h18
`define UPC_OFF_PEND   8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UPC_CTRL_RX_EN     0
`define UPC_CTRL_RX_EXT_LO 2
`define UPC_CTRL_RX_EXT_HI 5
`define UPC_CTRL_TX_EN     16
`define UPC_LIM_RX_LO      0
`define UPC_LIM_RX_HI      7
`define UPC_LIM_TX_LO      16
`define UPC_LIM_TX_HI      23
`define UPC_EVT_RX_FAIL    1
`define UPC_EVT_RX_PRES    2
`define UPC_EVT_TX_FAIL    17
`define UPC_EVT_TX_PRES    18

// ----------------------------------------
// Reset values and fixed counts
// ----------------------------------------
`define UPC_RST_WORD       32'h0000_0000
`define UPC_STD_CELL_LEN   7'h35
`endif

// ===== verilog/upc_pkg.sv
// Types shared by the port clock watch modules
package upc_pkg;

	// Watchdog states, one-hot
	typedef enum logic [2:0] {
		UPC_WD_OFF  = 3'b001,
		UPC_WD_RUN  = 3'b010,
		UPC_WD_FAIL = 3'b100
	} upc_wd_state_t;

	typedef struct packed {
		logic       tx_en;
		logic [3:0] rx_ext;
		logic       rx_en;
	} upc_ctrl_t;

	typedef struct packed {
		logic [7:0] tx;
		logic [7:0] rx;
	} upc_lim_t;

	// One bit per clock event, used for enables and pending flags
	typedef struct packed {
		logic tx_pres;
		logic tx_fail;
		logic rx_pres;
		logic rx_fail;
	} upc_evt_t;

	// Link-domain state of one watchdog
	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic tgl;
	} upc_link_t;

	// Peripheral-domain state of one watchdog
	typedef struct packed {
		logic          s1;
		logic          s2;
		logic          s3;
		logic [7:0]    cnt;
		upc_wd_state_t state;
	} upc_wd_t;

	typedef struct packed {
		upc_ctrl_t  ctrl;
		upc_lim_t   lim;
		upc_evt_t   ien;
		upc_evt_t   pend;
		logic [31:0] rdata;
		logic [6:0] cell_len;
		logic       rx_rst;
		logic       tx_rst;
		logic       irq;
		logic [8:0] rx_since;
		logic [8:0] tx_since;
	} upc_main_t;

endpackage

// ===== verilog/upc_clk_watch.sv
// One link clock supervisor: crossing, edge detect and timeout
`timescale 1ns/10ps
module upc_clk_watch #(
	parameter int CW = 8
) (
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	input  wire logic          link_clk_in,
	input  wire logic [CW-1:0] limit_in,
	output logic               edge_out,
	output logic               fail_out,
	output logic               failed_out
);
	import upc_pkg::*;

	upc_link_t ln_q;
	upc_link_t ln_d;
	upc_wd_t   wd_q;
	upc_wd_t   wd_d;
	logic      edge_seen;

	// ----------------------------------------
	// Link domain: toggle per rising edge
	// ----------------------------------------
	// Reset is brought over by two flops; a stopped clock keeps the toggle still
	always_comb begin
		ln_d          = ln_q;
		ln_d.rst_meta = rst_in;
		ln_d.rst_sync = ln_q.rst_meta;
		ln_d.tgl      = ln_q.rst_sync ? 1'b0 : ~ln_q.tgl;
	end

	always_ff @(posedge link_clk_in) begin
		ln_q <= ln_d;
	end

	// ----------------------------------------
	// Peripheral domain: sync and timeout
	// ----------------------------------------
	// Each toggle change is exactly one link rising edge
	assign edge_seen = wd_q.s2 ^ wd_q.s3;

	always_comb begin
		wd_d     = wd_q;
		fail_out = 1'b0;
		wd_d.s1  = ln_q.tgl;
		wd_d.s2  = wd_q.s1;
		wd_d.s3  = wd_q.s2;
		case (wd_q.state)
			UPC_WD_OFF: begin
				wd_d.cnt = '0;
				if (limit_in != '0) begin
					wd_d.state = UPC_WD_RUN;
				end
			end
			UPC_WD_RUN: begin
				if (limit_in == '0) begin
					wd_d.state = UPC_WD_OFF;
				end else if (edge_seen) begin
					wd_d.cnt = '0;
				end else if (wd_q.cnt >= limit_in - CW'(1)) begin
					wd_d.state = UPC_WD_FAIL;
					fail_out   = 1'b1;
				end else begin
					wd_d.cnt = wd_q.cnt + CW'(1);
				end
			end
			UPC_WD_FAIL: begin
				wd_d.cnt = '0;
				if (limit_in == '0) begin
					wd_d.state = UPC_WD_OFF;
				end else if (edge_seen) begin
					wd_d.state = UPC_WD_RUN;
				end
			end
			default: begin
				wd_d.state = UPC_WD_OFF;
			end
		endcase
		if (rst_in) begin
			wd_d = '{s1: 1'b0, s2: 1'b0, s3: 1'b0, cnt: '0, state: UPC_WD_OFF};
			fail_out = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		wd_q <= wd_d;
	end

	// Edge pulses and failed level for the register bank
	assign edge_out   = edge_seen & ~rst_in;
	assign failed_out = (wd_q.state == UPC_WD_FAIL);

endmodule // upc_clk_watch

// ===== verilog/upc_port_watch.sv
// Control registers and link clock supervision of the cell port
`timescale 1ns/10ps
`include "upc_cfg.svh"
module upc_port_watch (
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	input  wire logic  rx_link_clk_in,
	input  wire logic  tx_link_clk_in,
	input  wire logic  reg_wr_in,
	input  wire logic  reg_rd_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	output logic        rx_port_rst_out,
	output logic        tx_port_rst_out,
	output logic [3:0]  rx_ext_bytes_out,
	output logic [6:0]  rx_cell_len_out,
	output logic        irq_out
);
	import upc_pkg::*;

	upc_main_t st_q;
	upc_main_t st_d;

	logic rx_edge;
	logic rx_fail_evt;
	logic rx_failed;
	logic tx_edge;
	logic tx_fail_evt;
	logic tx_failed;

	logic wr_ctrl;
	logic wr_lim;
	logic wr_ien;
	logic wr_pend;
	upc_evt_t set_evt;
	upc_evt_t clr_evt;

	// ----------------------------------------
	// Link clock supervisors
	// ----------------------------------------
	upc_clk_watch #(
		.CW(8)
	) u_rx_watch (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.link_clk_in (rx_link_clk_in),
		.limit_in    (st_q.lim.rx),
		.edge_out    (rx_edge),
		.fail_out    (rx_fail_evt),
		.failed_out  (rx_failed)
	);

	upc_clk_watch #(
		.CW(8)
	) u_tx_watch (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.link_clk_in (tx_link_clk_in),
		.limit_in    (st_q.lim.tx),
		.edge_out    (tx_edge),
		.fail_out    (tx_fail_evt),
		.failed_out  (tx_failed)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Writes to unmapped offsets are dropped silently
	assign wr_ctrl = reg_wr_in && (reg_addr_in == `UPC_OFF_CTRL);
	assign wr_lim  = reg_wr_in && (reg_addr_in == `UPC_OFF_LIMITS);
	assign wr_ien  = reg_wr_in && (reg_addr_in == `UPC_OFF_IEN);
	assign wr_pend = reg_wr_in && (reg_addr_in == `UPC_OFF_PEND);

	// Hardware events that set flags
	always_comb begin
		set_evt.tx_pres = tx_edge;
		set_evt.tx_fail = tx_fail_evt;
		set_evt.rx_pres = rx_edge;
		set_evt.rx_fail = rx_fail_evt;
	end

	// Write-one-to-clear mask from the bus
	always_comb begin
		clr_evt.tx_pres = wr_pend & reg_wdata_in[`UPC_EVT_TX_PRES];
		clr_evt.tx_fail = wr_pend & reg_wdata_in[`UPC_EVT_TX_FAIL];
		clr_evt.rx_pres = wr_pend & reg_wdata_in[`UPC_EVT_RX_PRES];
		clr_evt.rx_fail = wr_pend & reg_wdata_in[`UPC_EVT_RX_FAIL];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;

		// Only implemented fields are stored; the rest read as zero
		if (wr_ctrl) begin
			st_d.ctrl.rx_en  = reg_wdata_in[`UPC_CTRL_RX_EN];
			st_d.ctrl.rx_ext =
				reg_wdata_in[`UPC_CTRL_RX_EXT_HI:`UPC_CTRL_RX_EXT_LO];
			st_d.ctrl.tx_en  = reg_wdata_in[`UPC_CTRL_TX_EN];
		end
		if (wr_lim) begin
			st_d.lim.rx = reg_wdata_in[`UPC_LIM_RX_HI:`UPC_LIM_RX_LO];
			st_d.lim.tx = reg_wdata_in[`UPC_LIM_TX_HI:`UPC_LIM_TX_LO];
		end
		if (wr_ien) begin
			st_d.ien.tx_pres = reg_wdata_in[`UPC_EVT_TX_PRES];
			st_d.ien.tx_fail = reg_wdata_in[`UPC_EVT_TX_FAIL];
			st_d.ien.rx_pres = reg_wdata_in[`UPC_EVT_RX_PRES];
			st_d.ien.rx_fail = reg_wdata_in[`UPC_EVT_RX_FAIL];
		end

		// A set in the same cycle as a clear wins, so no event is lost
		st_d.pend = (st_q.pend & ~clr_evt) | set_evt;

		// Read data captured one cycle after the strobe
		if (reg_rd_in) begin
			st_d.rdata = `UPC_RST_WORD;
			case (reg_addr_in)
				`UPC_OFF_CTRL: begin
					st_d.rdata[`UPC_CTRL_RX_EN] = st_q.ctrl.rx_en;
					st_d.rdata[`UPC_CTRL_RX_EXT_HI:`UPC_CTRL_RX_EXT_LO] =
						st_q.ctrl.rx_ext;
					st_d.rdata[`UPC_CTRL_TX_EN] = st_q.ctrl.tx_en;
				end
				`UPC_OFF_LIMITS: begin
					st_d.rdata[`UPC_LIM_RX_HI:`UPC_LIM_RX_LO] = st_q.lim.rx;
					st_d.rdata[`UPC_LIM_TX_HI:`UPC_LIM_TX_LO] = st_q.lim.tx;
				end
				`UPC_OFF_IEN: begin
					st_d.rdata[`UPC_EVT_TX_PRES] = st_q.ien.tx_pres;
					st_d.rdata[`UPC_EVT_TX_FAIL] = st_q.ien.tx_fail;
					st_d.rdata[`UPC_EVT_RX_PRES] = st_q.ien.rx_pres;
					st_d.rdata[`UPC_EVT_RX_FAIL] = st_q.ien.rx_fail;
				end
				`UPC_OFF_PEND: begin
					st_d.rdata[`UPC_EVT_TX_PRES] = st_q.pend.tx_pres;
					st_d.rdata[`UPC_EVT_TX_FAIL] = st_q.pend.tx_fail;
					st_d.rdata[`UPC_EVT_RX_PRES] = st_q.pend.rx_pres;
					st_d.rdata[`UPC_EVT_RX_FAIL] = st_q.pend.rx_fail;
				end
				default: begin
					st_d.rdata = `UPC_RST_WORD;
				end
			endcase
		end

		// Cell length: 53 plus extension bytes; codes above 11 are not trapped
		st_d.cell_len = `UPC_STD_CELL_LEN + {3'h0, st_q.ctrl.rx_ext};

		// Port resets: disabled or clock lost
		st_d.rx_rst = ~st_q.ctrl.rx_en | rx_failed;
		st_d.tx_rst = ~st_q.ctrl.tx_en | tx_failed;

		// Single interrupt from enabled pending flags
		st_d.irq = |(st_q.pend & st_q.ien);

		// Cycles since last detected edge, saturating
		st_d.rx_since = rx_edge ? 9'h000 :
			(&st_q.rx_since ? st_q.rx_since : st_q.rx_since + 9'h001);
		st_d.tx_since = tx_edge ? 9'h000 :
			(&st_q.tx_since ? st_q.tx_since : st_q.tx_since + 9'h001);

		if (rst_in) begin
			st_d        = '0;
			st_d.rx_rst = 1'b1;
			st_d.tx_rst = 1'b1;
			st_d.cell_len = `UPC_STD_CELL_LEN;
		end
	end

	always_ff @(posedge clk_in) begin
		st_q <= st_d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_out    = st_q.rdata;
	assign rx_port_rst_out  = st_q.rx_rst;
	assign tx_port_rst_out  = st_q.tx_rst;
	assign rx_ext_bytes_out = st_q.ctrl.rx_ext;
	assign rx_cell_len_out  = st_q.cell_len;
	assign irq_out          = st_q.irq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Standard cell when extension is zero
	AST_STD_CELL: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.ctrl.rx_ext == 4'h0 |=> rx_cell_len_out == 7'd53)
		else $error("cell length not 53 with zero extension");

	// Extended cell spans 54 to 64 bytes
	AST_UDC_CELL: assert property (@(posedge clk_in) disable iff (rst_in)
		(st_q.ctrl.rx_ext inside {[4'h1:4'hb]}) ##1 $stable(st_q.ctrl.rx_ext)
		|-> rx_cell_len_out == 7'd53 + {3'h0, st_q.ctrl.rx_ext})
		else $error("extended cell length wrong");

	// Disabled receiver stays in reset
	AST_RX_DIS: assert property (@(posedge clk_in) disable iff (rst_in)
		!st_q.ctrl.rx_en |=> rx_port_rst_out)
		else $error("receiver not held in reset while disabled");

	// Disabled transmitter stays in reset
	AST_TX_DIS: assert property (@(posedge clk_in) disable iff (rst_in)
		!st_q.ctrl.tx_en |=> tx_port_rst_out)
		else $error("transmitter not held in reset while disabled");

	// Reserved control bits read zero
	AST_RSVD: assert property (@(posedge clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == 8'h00
		|=> reg_rdata_out[13:6] == 8'h00 && !reg_rdata_out[1])
		else $error("reserved control bits read nonzero");

	// Transmit failure flags and resets the port
	AST_TX_FAIL: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_fail_evt |=> st_q.pend.tx_fail ##1 tx_port_rst_out)
		else $error("transmit failure not flagged or port not reset");

	// No transmit failure with limit zero
	AST_TX_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.lim.tx == 8'h00 |-> !tx_fail_evt)
		else $error("transmit failure while supervision off");

	// Receive failure flags and resets the port
	AST_RX_FAIL: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_fail_evt |=> st_q.pend.rx_fail ##1 rx_port_rst_out)
		else $error("receive failure not flagged or port not reset");

	// No receive failure with limit zero
	AST_RX_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.lim.rx == 8'h00 |-> !rx_fail_evt)
		else $error("receive failure while supervision off");

	// Failure only after the full window without an edge
	AST_RX_WIN: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_fail_evt |-> !rx_edge && st_q.rx_since >= {1'b0, st_q.lim.rx} - 9'h001)
		else $error("receive failure before window elapsed");

	// Receive presence flag follows detected edges
	AST_PRES: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_edge |=> st_q.pend.rx_pres)
		else $error("receive presence flag not set on edge");

	// Interrupt follows pending and enable
	AST_IRQ: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.pend.tx_fail && st_q.ien.tx_fail |=> irq_out)
		else $error("interrupt missing for enabled pending flag");

	// Write one clears a flag with no new event
	AST_W1C: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_pend && reg_wdata_in[1] && !rx_fail_evt |=> !st_q.pend.rx_fail)
		else $error("write one did not clear receive fail flag");

	// Enable bits land at their positions
	AST_IEN: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_ien |=> st_q.ien.tx_pres == $past(reg_wdata_in[18])
		&& st_q.ien.rx_pres == $past(reg_wdata_in[2]))
		else $error("enable bit position wrong");

	// Failed-enable bits land at their positions
	AST_IEN_FAIL: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_ien |=> st_q.ien.tx_fail == $past(reg_wdata_in[17])
		&& st_q.ien.rx_fail == $past(reg_wdata_in[1]))
		else $error("fail enable bit position wrong");

	// Extension field lands at bits 5 to 2
	AST_EXT_WR: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_ctrl |=> rx_ext_bytes_out == $past(reg_wdata_in[5:2]))
		else $error("extension field not stored");

	// Limits read back with reserved bits zero
	AST_LIM_RD: assert property (@(posedge clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == `UPC_OFF_LIMITS
		|=> reg_rdata_out == {8'h00, $past(st_q.lim.tx), 8'h00, $past(st_q.lim.rx)})
		else $error("limits read back wrong");

	// Presence flags read back at their positions
	AST_PEND_RD: assert property (@(posedge clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == `UPC_OFF_PEND
		|=> reg_rdata_out[2] == $past(st_q.pend.rx_pres)
		&& reg_rdata_out[18] == $past(st_q.pend.tx_pres))
		else $error("presence flags read back wrong");

	// Enabled receiver with its clock leaves reset
	AST_RX_RUN: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.ctrl.rx_en && !rx_failed |=> !rx_port_rst_out)
		else $error("enabled receiver held in reset");

	// Enabled transmitter with its clock leaves reset
	AST_TX_RUN: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.ctrl.tx_en && !tx_failed |=> !tx_port_rst_out)
		else $error("enabled transmitter held in reset");

	// Lost receive clock keeps the port in reset
	AST_RX_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_failed |=> rx_port_rst_out)
		else $error("receive port left reset while clock lost");

	// Lost transmit clock keeps the port in reset
	AST_TX_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_failed |=> tx_port_rst_out)
		else $error("transmit port left reset while clock lost");

	// Zero receive limit clears any failed state
	AST_RX_NORST: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.lim.rx == 8'h00 |=> !rx_failed)
		else $error("receive failed state with supervision off");

	// Zero transmit limit clears any failed state
	AST_TX_NORST: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.lim.tx == 8'h00 |=> !tx_failed)
		else $error("transmit failed state with supervision off");

	// Transmit failure only after the full window
	AST_TX_WIN: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_fail_evt |-> !tx_edge && st_q.tx_since >= {1'b0, st_q.lim.tx} - 9'h001)
		else $error("transmit failure before window elapsed");

	// A detected edge ends the failed state
	AST_RX_RECOVER: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_failed && rx_edge |=> !rx_failed)
		else $error("receive failed state kept after an edge");

	// Transmit presence flag follows detected edges
	AST_TX_PRES: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_edge |=> st_q.pend.tx_pres)
		else $error("transmit presence flag not set on edge");

	// Receive failure interrupt when enabled
	AST_IRQ_RX: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q.pend.rx_fail && st_q.ien.rx_fail |=> irq_out)
		else $error("interrupt missing for receive failure");

	// No interrupt without an enabled pending flag
	AST_IRQ_QUIET: assert property (@(posedge clk_in) disable iff (rst_in)
		(st_q.pend & st_q.ien) == 4'h0 |=> !irq_out)
		else $error("interrupt without enabled pending flag");

	// Write zero leaves a flag set
	AST_W1C_KEEP: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_pend && !reg_wdata_in[17] && st_q.pend.tx_fail |=> st_q.pend.tx_fail)
		else $error("write zero cleared transmit fail flag");

	// Write one clears the transmit fail flag
	AST_TX_W1C: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_pend && reg_wdata_in[17] && !tx_fail_evt |=> !st_q.pend.tx_fail)
		else $error("write one did not clear transmit fail flag");

endmodule // upc_port_watch

// ===== verif/upc_link_master.sv
// Model of the cell-layer master that supplies both link clocks
`timescale 1ns/10ps
module upc_link_master (
	input  wire logic rx_run_in,
	input  wire logic tx_run_in,
	output logic      rx_clk_out,
	output logic      tx_clk_out
);
	// ----------------------------------------
	// Link clocks, 125 ns period
	// ----------------------------------------
	// A stopped clock parks low so no stray rising edge reaches the watchdog
	initial begin
		rx_clk_out = 1'b0;
		tx_clk_out = 1'b0;
	end

	// Receive clock runs while asked to
	always begin
		#62.5;
		rx_clk_out = rx_run_in ? ~rx_clk_out : 1'b0;
	end

	// Transmit clock offset in phase from the receive clock
	initial begin
		#17.3;
		forever begin
			#62.5;
			tx_clk_out = tx_run_in ? ~tx_clk_out : 1'b0;
		end
	end
endmodule // upc_link_master

// ===== verif/upc_port_watch_tb.sv
// Self-checking bench for the port clock watch block
`timescale 1ns/10ps
module upc_port_watch_tb;
	logic        clk_in       = 1'b0;
	logic        rst_in       = 1'b1;
	logic        reg_wr_in    = 1'b0;
	logic        reg_rd_in    = 1'b0;
	logic [7:0]  reg_addr_in  = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0000_0000;
	logic        rx_run       = 1'b1;
	logic        tx_run       = 1'b1;
	logic        rx_link_clk;
	logic        tx_link_clk;
	logic [31:0] reg_rdata_out;
	logic        rx_port_rst_out;
	logic        tx_port_rst_out;
	logic [3:0]  rx_ext_bytes_out;
	logic [6:0]  rx_cell_len_out;
	logic        irq_out;
	int          error_cnt    = 0;
	int          comparisons  = 0;
	int          seed         = 14014;

	// ----------------------------------------
	// Clock, partner and design
	// ----------------------------------------
	always #2 clk_in = ~clk_in;

	upc_link_master upc_link_master_i (
		.rx_run_in  (rx_run),
		.tx_run_in  (tx_run),
		.rx_clk_out (rx_link_clk),
		.tx_clk_out (tx_link_clk)
	);

	upc_port_watch upc_port_watch_i (
		.clk_in           (clk_in),
		.rst_in           (rst_in),
		.rx_link_clk_in   (rx_link_clk),
		.tx_link_clk_in   (tx_link_clk),
		.reg_wr_in        (reg_wr_in),
		.reg_rd_in        (reg_rd_in),
		.reg_addr_in      (reg_addr_in),
		.reg_wdata_in     (reg_wdata_in),
		.reg_rdata_out    (reg_rdata_out),
		.rx_port_rst_out  (rx_port_rst_out),
		.tx_port_rst_out  (tx_port_rst_out),
		.rx_ext_bytes_out (rx_ext_bytes_out),
		.rx_cell_len_out  (rx_cell_len_out),
		.irq_out          (irq_out)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Compare and count, report a mismatch at once
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One-cycle write strobe, register holds value after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		#1;
		reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(posedge clk_in);
		#1;
		reg_wr_in = 1'b0;
	endtask

	// One-cycle read strobe, data lands on the following edge
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk_in);
		#1;
		reg_rd_in = 1'b1;
		reg_addr_in = a;
		@(posedge clk_in);
		#1;
		reg_rd_in = 1'b0;
		check(reg_rdata_out, exp, what);
	endtask

	// Expected receive cell length for an extension code
	function automatic logic [6:0] cell_len(input logic [3:0] ext);
		return 7'h35 + {3'h0, ext};
	endfunction

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 1500 cycles
	initial begin
		#40000;
		error_cnt++;
		final_report();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [3:0]  ext;
		int          sh;
		// Long reset so the link-side synchronisers see several link edges
		repeat (100) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		check({31'h0, rx_port_rst_out}, 32'h1, "rx rst after reset");
		check({31'h0, tx_port_rst_out}, 32'h1, "tx rst after reset");
		check({25'h0, rx_cell_len_out}, 32'h35, "cell len after reset");
		rd(8'h00, 32'h0, "ctrl reset");
		rd(8'h14, 32'h0, "limits reset");
		rd(8'h18, 32'h0, "enable reset");
		rd(8'h04, 32'h0, "unmapped read");
		$display("Test reset values done");

		// Every legal extension code, then random ones; reserved codes never written
		for (int i = 0; i < 32; i++) begin
			ext = (i < 12) ? i[3:0] : 4'($unsigned($random(seed)) % 12);
			d = $random(seed);
			d[5:2] = ext;
			wr(8'h00, d);
			rd(8'h00, d & 32'h0001_003d, "ctrl readback");
			check({28'h0, rx_ext_bytes_out}, {28'h0, ext}, "ext bytes");
			check({25'h0, rx_cell_len_out}, {25'h0, cell_len(ext)}, "cell len");
			check({31'h0, rx_port_rst_out}, {31'h0, ~d[0]}, "rx enable");
			check({31'h0, tx_port_rst_out}, {31'h0, ~d[16]}, "tx enable");
		end
		d = $random(seed);
		wr(8'h14, d);
		rd(8'h14, d & 32'h00ff_00ff, "limits readback");
		d = $random(seed);
		wr(8'h18, d);
		rd(8'h18, d & 32'h0006_0006, "enable readback");
		wr(8'h04, 32'hffff_ffff);
		rd(8'h04, 32'h0, "unmapped write");
		$display("Test register access done");

		// Both clocks running inside the widest window
		wr(8'h00, 32'h0001_0001);
		wr(8'h14, 32'h00ff_00ff);
		wr(8'h18, 32'h0);
		// Drop fail flags left behind by the random limits above
		wr(8'h1c, 32'h0006_0006);
		repeat (100) @(posedge clk_in);
		rd(8'h1c, 32'h0004_0004, "present flags");
		check({30'h0, rx_port_rst_out, tx_port_rst_out}, 32'h0, "ports running");

		// Stop one clock at a time: fail, reset, interrupt, clear, recover
		for (int dir = 0; dir < 2; dir++) begin
			sh = dir * 16;
			if (dir == 0) rx_run = 1'b0;
			else tx_run = 1'b0;
			repeat (300) @(posedge clk_in);
			rd(8'h1c, 32'h0004_0004 | (32'h2 << sh), "fail flag");
			check({30'h0, tx_port_rst_out, rx_port_rst_out}, 32'h1 << dir, "port rst");
			check({31'h0, irq_out}, 32'h0, "irq masked");
			wr(8'h18, 32'h2 << sh);
			repeat (2) @(posedge clk_in);
			#1;
			check({31'h0, irq_out}, 32'h1, "irq raised");
			wr(8'h1c, 32'h0);
			rd(8'h1c, 32'h0004_0004 | (32'h2 << sh), "write zero keeps");
			wr(8'h1c, 32'h6 << sh);
			rd(8'h1c, 32'h0004_0004 & ~(32'h4 << sh), "write one clears");
			check({31'h0, irq_out}, 32'h0, "irq dropped");
			wr(8'h18, 32'h0);
			rx_run = 1'b1;
			tx_run = 1'b1;
			repeat (100) @(posedge clk_in);
			#1;
			check({30'h0, rx_port_rst_out, tx_port_rst_out}, 32'h0, "recovered");
			$display("Test clock loss direction %0d done", dir);
		end

		// Zero limits switch supervision off
		wr(8'h14, 32'h0);
		wr(8'h18, 32'h0006_0006);
		rx_run = 1'b0;
		tx_run = 1'b0;
		repeat (20) @(posedge clk_in);
		wr(8'h1c, 32'h0006_0006);
		repeat (300) @(posedge clk_in);
		rd(8'h1c, 32'h0, "no fail at zero limit");
		check({30'h0, rx_port_rst_out, tx_port_rst_out}, 32'h0, "no reset");
		check({31'h0, irq_out}, 32'h0, "no irq");
		$display("Test zero limits done");
		final_report();
	end
endmodule // upc_port_watch_tb
